/* File: logic/swe_device.sv */
`timescale 1ns/10ps
`default_nettype none
`include "swe_params.svh"
module swe_device
	import swe_pkg::*;
#(
	parameter int unsigned WR_CYC = `SWE_WR_CYC
) (
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	swe_if.device     bus,
	output logic      busy_o,
	output logic      active_o,
	output logic      wr_refused_o
);
	localparam int unsigned AW = `SWE_ADDR_W;
	localparam int unsigned DW = `SWE_WORD_W;

	logic [DW-1:0] mem [`SWE_DEPTH];
	logic          sck_d;
	logic          sel_d;
	logic          started;
	logic [5:0]    cnt;
	logic [26:0]   shreg;
	logic [DW-1:0] obuf;
	logic          obit;
	logic          oe_n;
	logic          reading;
	logic [AW-1:0] raddr;
	logic          wen;
	logic          pend;
	logic [AW-1:0] pend_addr;
	logic [DW-1:0] pend_data;
	logic [31:0]   wtimer;
	logic          refused;
	logic          rise;
	logic          fall_sel;
	logic [26:0]   next_shreg;
	logic          commit;
	swe_pwr_e      pwr;

	assign rise = bus.sel && bus.sck && !sck_d;
	assign fall_sel = sel_d && !bus.sel;
	assign next_shreg = {shreg[25:0], bus.din};
	assign commit = pend && (wtimer == 32'h0);

	function automatic logic [1:0] op_of(input logic [26:0] s, input logic [5:0] n);
		logic [5:0] sh;
		sh = n - 6'd3;
		op_of = 2'((s >> sh) & 27'h3);
	endfunction

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sck_d <= 1'b0;
			sel_d <= 1'b0;
		end else begin
			sck_d <= bus.sck;
			sel_d <= bus.sel;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			started <= 1'b0;
			cnt <= 6'h00;
			shreg <= 27'h0;
		end else if (!bus.sel) begin
			started <= 1'b0;
			cnt <= 6'h00;
			shreg <= 27'h0;
		end else if (rise) begin
			if (!started) begin
				started <= bus.din;
				cnt <= bus.din ? 6'h01 : 6'h00;
				shreg <= 27'h0;
			end else begin
				// saturate so a runaway clock cannot wrap
				if (cnt != 6'h3f)
					cnt <= cnt + 6'h01;
				shreg <= next_shreg;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reading <= 1'b0;
			raddr <= 8'h00;
			obuf <= 16'h0000;
			obit <= 1'b0;
			oe_n <= 1'b1;
		end else if (!bus.sel) begin
			reading <= 1'b0;
			oe_n <= 1'b1;
		end else if (rise && started) begin
			if (!reading && cnt == 6'(`SWE_HDR_CNT - 1)
					&& next_shreg[9:8] == 2'(SWE_OP_READ) && !bus.prot_en) begin
				reading <= 1'b1;
				raddr <= next_shreg[7:0] + 8'h01;
				obuf <= mem[next_shreg[7:0]];
				obit <= 1'b0;
				oe_n <= 1'b0;
			end else if (reading) begin
				obit <= obuf[DW-1];
				obuf <= {obuf[DW-2:0], 1'b0};
				// reload next word as the last bit leaves
				if (cnt[3:0] == 4'ha) begin
					obuf <= mem[raddr];
					raddr <= raddr + 8'h01;
				end
			end
		end else if (bus.sel && !started && pend) begin
			obit <= 1'b0;
			oe_n <= 1'b0;
		end else if (bus.sel && !started && !pend && !reading) begin
			obit <= 1'b1;
			oe_n <= !sel_d ? 1'b1 : oe_n;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wen <= 1'b0;
			pend <= 1'b0;
			pend_addr <= 8'h00;
			pend_data <= `SWE_RST_WORD;
			wtimer <= 32'h0;
			refused <= 1'b0;
		end else begin
			refused <= 1'b0;
			if (pend) begin
				// write runs to end regardless of select
				if (commit) begin
					pend <= 1'b0;
				end else begin
					wtimer <= wtimer - 32'h1;
				end
			end else if (fall_sel && started && !bus.prot_en) begin
				// only an exact pulse count commits
				if (cnt == 6'(`SWE_CMD_CNT) && op_of(shreg, cnt) == 2'(SWE_OP_EXT)) begin
					if (shreg[7:6] == 2'b11)
						wen <= 1'b1;
					else if (shreg[7:6] == 2'b00)
						wen <= 1'b0;
				end else if (cnt == 6'(`SWE_WR_CNT) && shreg[25:24] == 2'(SWE_OP_WRITE)) begin
					if (wen && bus.wr_inh_n) begin
						pend <= 1'b1;
						pend_addr <= shreg[23:16];
						pend_data <= shreg[15:0];
						wtimer <= 32'(WR_CYC - 1);
					end else begin
						refused <= 1'b1;
					end
				end
			end
		end
	end

	// array updated when the write cycle ends
	always_ff @(posedge ref_clk_i) begin
		if (commit)
			mem[pend_addr] <= pend_data;
	end

	always_comb begin
		if (bus.sel)
			pwr = SWE_PWR_ACTIVE;
		else if (pend)
			pwr = SWE_PWR_WRITING;
		else
			pwr = SWE_PWR_STANDBY;
	end

	assign bus.dout = obit;
	assign bus.dout_oe_n = bus.sel ? oe_n : 1'b1;
	assign busy_o = pend;
	assign active_o = (pwr == SWE_PWR_ACTIVE);
	assign wr_refused_o = refused;
endmodule
`default_nettype wire

/* File: logic/swe_params.svh */
`ifndef SWE_PARAMS_SVH
`define SWE_PARAMS_SVH
`define SWE_ADDR_W      8
`define SWE_WORD_W      16
`define SWE_DEPTH       256
`define SWE_OP_W        2
`define SWE_HDR_CNT     11
`define SWE_WR_CNT      27
`define SWE_CMD_CNT     11
`define SWE_T_WRITE_NS  5000000
`define SWE_WR_CYC      ((`SWE_T_WRITE_NS + 4) / 5)
`define SWE_SCK_HALF    4
`define SWE_RST_WORD    16'hffff
`endif

/* File: logic/swe_pkg.sv */
`default_nettype none
package swe_pkg;
	typedef enum logic [1:0] {
		SWE_OP_EXT,
		SWE_OP_WRITE,
		SWE_OP_READ,
		SWE_OP_PAGE
	} swe_op_e;
	typedef enum logic [1:0] {
		SWE_PWR_STANDBY,
		SWE_PWR_ACTIVE,
		SWE_PWR_WRITING
	} swe_pwr_e;
endpackage
`default_nettype wire

/* File: logic/swe_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface swe_if;
	logic sel;
	logic sck;
	logic din;
	logic dout;
	logic dout_oe_n;
	logic prot_en;
	logic wr_inh_n;
	modport device (
		input  sel,
		input  sck,
		input  din,
		output dout,
		output dout_oe_n,
		input  prot_en,
		input  wr_inh_n
	);
	modport host (
		output sel,
		output sck,
		output din,
		input  dout,
		input  dout_oe_n,
		output prot_en,
		output wr_inh_n
	);
endinterface
`default_nettype wire

/* File: logic/swe_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "swe_params.svh"
module swe_host
	import swe_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	swe_if.host              bus,
	input  wire logic        req_i,
	input  wire logic [1:0]  op_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        prot_i,
	input  wire logic        wr_inh_n_i,
	output logic             done_o,
	output logic [15:0]      rdata_o
);
	typedef enum logic [1:0] {
		SWE_H_IDLE,
		SWE_H_LOW,
		SWE_H_HIGH,
		SWE_H_END
	} swe_hst_e;

	swe_hst_e    st;
	logic [2:0]  div;
	logic [5:0]  nbits;
	logic [5:0]  idx;
	logic [26:0] frame;
	logic        rd;
	logic [15:0] rsh;
	logic        sck;
	logic        sel;
	logic        din;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= SWE_H_IDLE;
			div <= 3'h0;
			nbits <= 6'h00;
			idx <= 6'h00;
			frame <= 27'h0;
			rd <= 1'b0;
			rsh <= 16'h0000;
			sck <= 1'b0;
			sel <= 1'b0;
			din <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 16'h0000;
		end else begin
			done_o <= 1'b0;
			case (st)
				SWE_H_IDLE: begin
					sck <= 1'b0;
					if (req_i) begin
						sel <= 1'b1;
						rd <= (op_i == 2'(SWE_OP_READ));
						nbits <= (op_i == 2'(SWE_OP_EXT)) ? 6'(`SWE_CMD_CNT) :
							(op_i == 2'(SWE_OP_READ)) ? 6'(`SWE_WR_CNT) : 6'(`SWE_WR_CNT);
						frame <= {1'b1, op_i, addr_i, wdata_i};
						idx <= 6'h00;
						div <= 3'h0;
						st <= SWE_H_LOW;
					end
				end
				SWE_H_LOW: begin
					din <= frame[26];
					div <= div + 3'h1;
					if (div == 3'(`SWE_SCK_HALF)) begin
						div <= 3'h0;
						sck <= 1'b1;
						st <= SWE_H_HIGH;
					end
				end
				SWE_H_HIGH: begin
					div <= div + 3'h1;
					if (div == 3'(`SWE_SCK_HALF)) begin
						div <= 3'h0;
						sck <= 1'b0;
						frame <= {frame[25:0], 1'b0};
						idx <= idx + 6'h01;
						// read bit after device shifted it
						if (rd && idx >= 6'(`SWE_HDR_CNT))
							rsh <= {rsh[14:0], bus.dout};
						st <= (idx + 6'h01 == nbits) ? SWE_H_END : SWE_H_LOW;
					end
				end
				SWE_H_END: begin
					sel <= 1'b0;
					din <= 1'b0;
					done_o <= 1'b1;
					rdata_o <= rd ? rsh : rdata_o;
					st <= SWE_H_IDLE;
				end
				default: st <= SWE_H_IDLE;
			endcase
		end
	end

	assign bus.sel = sel;
	assign bus.sck = sck;
	assign bus.din = din;
	assign bus.prot_en = prot_i;
	assign bus.wr_inh_n = wr_inh_n_i;
endmodule
`default_nettype wire

/* File: tb/swe_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module swe_properties (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic sel,
	input wire logic sck,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe_n,
	input wire logic prot_en,
	input wire logic wr_inh_n
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_high_phase;
		sck[*5] ##1 !sck;
	endsequence
	sequence s_frame_end;
		##[1:400] !sel;
	endsequence
	a_sck_high_len: assert property ($rose(sck) |-> s_high_phase)
		else $error("clock high phase length");
	a_din_stable_rise: assert property ($rose(sck) |-> $stable(din))
		else $error("data moved at clock rise");
	a_dout_after_rise: assert property (!dout_oe_n && $past(!dout_oe_n) && $changed(dout) |-> sck && $past(sck))
		else $error("output moved off clock rise");
	a_oe_off_desel: assert property (!sel [*2] |-> dout_oe_n)
		else $error("output driven while deselected");
	a_sck_low_select: assert property ($rose(sel) |-> !sck [*3])
		else $error("clock high at select");
	a_sck_still_idle: assert property (!sel |-> !sck)
		else $error("clock runs while deselected");
	a_prot_held: assert property (sel && $past(sel) |-> $stable(prot_en))
		else $error("protect enable moved in frame");
	a_frame_bounded: assert property ($rose(sel) |-> s_frame_end)
		else $error("frame too long");
	a_reset_idle: assert property ($fell(sys_rst_i) |-> !sel && dout_oe_n)
		else $error("not idle after reset");
endmodule
`default_nettype wire

/* File: tb/swe_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module swe_tb;
	import swe_pkg::*;
	logic        clk = 0, rst = 1, req = 0, prot = 0, inh_n = 1;
	logic [1:0]  op = 0;
	logic [7:0]  addr = 0;
	logic [15:0] wdata = 0, rdata, refusals = 0;
	logic        done, busy, active, refused, busy_b;
	int          mismatches = 0, checks_done = 0;
	swe_if bus();
	swe_if bus_b();
	swe_host u_swe_host (.ref_clk_i(clk), .sys_rst_i(rst), .bus(bus), .req_i(req), .op_i(op), .addr_i(addr),
		.wdata_i(wdata), .prot_i(prot), .wr_inh_n_i(inh_n), .done_o(done), .rdata_o(rdata));
	swe_device #(.WR_CYC(20)) u_swe_device (.ref_clk_i(clk), .sys_rst_i(rst), .bus(bus), .busy_o(busy),
		.active_o(active), .wr_refused_o(refused));
	swe_device #(.WR_CYC(20)) u_swe_device_b (.ref_clk_i(clk), .sys_rst_i(rst), .bus(bus_b), .busy_o(busy_b),
		.active_o(), .wr_refused_o());
	swe_properties u_swe_properties (.ref_clk_i(clk), .sys_rst_i(rst), .sel(bus.sel), .sck(bus.sck),
		.din(bus.din), .dout(bus.dout), .dout_oe_n(bus.dout_oe_n), .prot_en(bus.prot_en),
		.wr_inh_n(bus.wr_inh_n));
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) if (refused === 1'b1) refusals <= refusals + 16'h1;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic run(input logic [1:0] o, input logic [7:0] a, input logic [15:0] d);
		int n;
		@(negedge clk);
		{req, op, addr, wdata} = {1'b1, o, a, d};
		@(negedge clk);
		req = 1'b0;
		for (n = 0; done !== 1'b1 && n < 2000; n++) @(negedge clk);
		if (n == 2000) mismatches++;
		repeat (3) @(negedge clk);
		for (n = 0; busy !== 1'b0 && n < 2000; n++) @(negedge clk);
		if (n == 2000) mismatches++;
	endtask
	// bit-bang the second link, pulse count chosen by caller
	task automatic bang(input int n, input logic [26:0] v);
		bus_b.sel = 1'b1;
		for (int i = 26; i > 26 - n; i--) begin
			bus_b.din = v[i];
			repeat (3) @(negedge clk);
			bus_b.sck = 1'b1;
			repeat (3) @(negedge clk);
			bus_b.sck = 1'b0;
		end
		bus_b.sel = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	always @(negedge clk) if (!rst) check({15'h0, active}, {15'h0, bus.sel});
	initial begin
		{bus_b.sel, bus_b.sck, bus_b.din, bus_b.prot_en, bus_b.wr_inh_n} = 5'b00001;
		repeat (4) @(negedge clk);
		rst = 0;
		run(2'h0, 8'hc0, 16'h0);
		run(2'h1, 8'h00, 16'ha5c3);
		run(2'h2, 8'h00, 16'h0);
		check(rdata, 16'ha5c3);
		run(2'h1, 8'hff, 16'h1234);
		run(2'h2, 8'hff, 16'h0);
		check(rdata, 16'h1234);
		inh_n = 0;
		run(2'h1, 8'h00, 16'h0f0f);
		inh_n = 1;
		check(refusals, 16'h1);
		prot = 1;
		run(2'h1, 8'h00, 16'h0f0f);
		prot = 0;
		run(2'h0, 8'h00, 16'h0);
		run(2'h1, 8'h00, 16'h0f0f);
		run(2'h2, 8'h00, 16'h0);
		check(rdata, 16'ha5c3);
		bang(11, {11'b100_11000000, 16'h0});
		bang(26, {11'b101_00000011, 16'h5555});
		check({15'h0, busy_b}, 16'h0);
		bang(27, {11'b101_00000011, 16'h5555});
		check({15'h0, busy_b}, 16'h1);
		repeat (25) @(negedge clk);
		check({15'h0, busy_b}, 16'h0);
		rst = 1;
		@(negedge clk);
		check({14'h0, busy_b, bus.dout_oe_n}, 16'h1);
		bang(11, {11'b100_11000000, 16'h0});
		rst = 0;
		bang(27, {11'b101_00000011, 16'h5555});
		check({15'h0, busy_b}, 16'h0);
		run(2'h2, 8'h00, 16'h0);
		check(rdata, 16'ha5c3);
		final_report();
	end
	initial begin
		#200000;
		mismatches++;
		final_report();
	end
endmodule
`default_nettype wire
